/* File: verilog/wbc_pkg.sv */
// shared constants, register map and field layout of the waveform burst controller
// assumes a single 100 MHz ref_clk and a plain address/strobe register port
package wbc_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int GAP_NS = 200;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // widths
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ACC_W = 48;
  localparam int CYC_W = 20;
  localparam int PER_CLK_W = 36;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CYCLES = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FREQ_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FREQ_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_GATED_BIT = 1;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_SLOPE_BIT = 5;
  localparam int CTRL_SWEEP_BIT = 6;
  localparam int CTRL_MOD_BIT = 7;
  localparam int CTRL_SHAPE_LSB = 8;
  localparam int CYC_INF_BIT = 31;
  localparam int TRIG_BUS_BIT = 0;

  // ==========================================================================
  // limits and reset values
  // ==========================================================================
  localparam logic [CYC_W-1:0] CYC_MIN = 20'h00001;
  localparam logic [CYC_W-1:0] CYC_MAX = 20'hf4240;
  localparam logic [CYC_W-1:0] CYC_DEF = 20'h00001;
  localparam logic [31:0] PER_MIN_US = 32'h00000001;
  localparam logic [31:0] PER_MAX_US = 32'h1dcd6500;
  localparam logic [31:0] PER_DEF_US = 32'h00002710;
  localparam logic signed [31:0] PHASE_MAX_DEG = 32'sh00000168;
  localparam logic [31:0] DELAY_DEF = 32'h00000000;
  localparam logic [63:0] ACC_SPAN = 64'h0001_0000_0000_0000;
  // phase increments per clock for the frequency limits and the default frequency, then the phase of one degree
  localparam logic [ACC_W-1:0] INC_MIN = ACC_W'((ACC_SPAN + 64'hba43b73ff) / 64'hba43b7400);
  localparam logic [ACC_W-1:0] INC_MAX = ACC_W'((ACC_SPAN * 64'h4) / 64'h5);
  localparam logic [ACC_W-1:0] INC_RAMP_MAX = ACC_W'(ACC_SPAN / 64'h64);
  localparam logic [ACC_W-1:0] INC_ARB_MAX = ACC_W'(ACC_SPAN / 64'h4);
  localparam logic [ACC_W-1:0] INC_DEF = ACC_W'(ACC_SPAN / 64'h186a0);
  localparam logic [ACC_W-1:0] PH_PER_DEG = ACC_W'(ACC_SPAN / 64'h168);

  // ==========================================================================
  // enumerations
  // ==========================================================================
  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_BUS, SRC_BUS2} wbc_src_e;
  typedef enum logic [2:0] {SH_SINE, SH_SQUARE, SH_RAMP, SH_PULSE, SH_ARB, SH_NOISE, SH_DC, SH_BAD} wbc_shape_e;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} wbc_state_e;

endpackage

/* File: verilog/wbc_sync.sv */
// two-stage synchroniser for the rear trigger/gate input
// assumes the input is asynchronous to ref_clk
`timescale 1ns/10ps
module wbc_sync
  import wbc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);

  typedef struct packed {
    logic stage2;
    logic stage1;
  } wbc_sync_s;

  wbc_sync_s s_ff;
  wbc_sync_s nxt_s;

  // ==========================================================================
  // stage one is read only by stage two
  // ==========================================================================
  always_comb
  begin
    nxt_s.stage1 = async_in;
    nxt_s.stage2 = s_ff.stage1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign sync_out = s_ff.stage2;

endmodule

/* File: verilog/wbc_dcount.sv */
// loadable down counter that stops at zero
// assumes load has priority over counting
`timescale 1ns/10ps
module wbc_dcount
  import wbc_pkg::*;
#(
  parameter int W = 32
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic zero
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } wbc_dcount_s;

  wbc_dcount_s s_ff;
  wbc_dcount_s nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (load)
      nxt_s.cnt = load_val;
    else if (s_ff.cnt != '0)
      nxt_s.cnt = s_ff.cnt - W'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign zero = (s_ff.cnt == '0);

endmodule

/* File: verilog/wbc_burst_ctrl.sv */
// burst controller: triggered and gated bursts driving a phase accumulator
// assumes synchronous register strobes and an asynchronous rear trigger/gate pin
//
// How it works
// - burst enable clears sweep and modulation
// - noise only gated, dc never bursts
// - triggered: exact cycle count, then halt
// - gated: waveform runs while gate asserted
// - gate drop: finish cycle, hold start phase
// - noise gated: stop at once on drop
// - gated ignores count, period, trigger source (the infinite count bit still sets the sine/square cap)
// - gated mode drops manual triggers silently
// - gate polarity normal or gate_active_low, normal default
// - frequency 2 mHz..80 MHz, ramp/arb caps
// - sine/square above 25 MHz need infinite
// - count 1..1000000 or infinite, default 1
// - internal trigger repeats every burst period (a nonzero delay adds the delay plus one clock)
// - long count stretches period, frequency kept
// - count written in gated mode kept
// - period 1 us..500 s, default 10 ms
// - period exceeds burst length plus 200 ns
// - start phase -360..+360, used every burst
// - phase ignored for pulse and noise
// - one burst per edge, ignore while busy
// - programmable delay before triggered burst
// - reset: triggered mode, internal source
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module wbc_burst_ctrl
  import wbc_pkg::*;
#(
  parameter int US_CYC = CYC_PER_US
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic trig_gate_in,
  output logic [ACC_W-1:0] phase_word,
  output logic wave_run,
  output logic burst_hold,
  output logic sweep_enable,
  output logic mod_enable
);

  typedef struct packed {
    logic en;
    logic gated;
    logic pol;
    logic slope;
    logic sweep;
    logic modu;
    wbc_src_e src;
    wbc_shape_e shape;
    logic cyc_inf;
    logic [CYC_W-1:0] cyc_cnt;
    logic [31:0] per_us;
    logic [9:0] phase;
    logic [ACC_W-1:0] freq;
    logic [31:0] delay;
    wbc_state_e st;
    logic [ACC_W-1:0] rel;
    logic [CYC_W-1:0] done_cnt;
    logic [7:0] gap;
    logic trg_prev;
    logic [ACC_W-1:0] phase_word;
    logic wave_run;
    logic [DATA_W-1:0] rd_data;
  } wbc_core_s;

  wbc_core_s s_ff;
  wbc_core_s nxt_s;

  logic trg_s;
  logic per_zero;
  logic dly_zero;
  logic per_load;
  logic dly_load;
  logic [PER_CLK_W-1:0] per_clk;
  logic [ACC_W-1:0] inc;
  logic [ACC_W-1:0] inc_cap;
  logic [ACC_W-1:0] ph_off;
  logic [9:0] ph_deg;
  logic [ACC_W:0] acc_sum;
  logic wrap;
  logic cfg_ok;
  logic active;
  logic gate_on;
  logic ext_edge;
  logic bus_trig;
  logic trig_req;
  logic last_cycle;
  logic noise;

  // ==========================================================================
  // input synchroniser and counters
  // ==========================================================================
  wbc_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(trig_gate_in),
    .sync_out(trg_s)
  );

  wbc_dcount #(.W(PER_CLK_W)) u_period (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(per_load),
    .load_val(per_clk - PER_CLK_W'(1)),
    .zero(per_zero)
  );

  wbc_dcount #(.W(32)) u_delay (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(dly_load),
    .load_val(s_ff.delay),
    .zero(dly_zero)
  );

  // ==========================================================================
  // decoded configuration
  // ==========================================================================
  always_comb
  begin
    noise = (s_ff.shape == SH_NOISE);
    cfg_ok = (s_ff.shape <= SH_ARB) || (noise && s_ff.gated);
    active = s_ff.en && cfg_ok;
    gate_on = trg_s ^ s_ff.pol;
    ext_edge = s_ff.slope ? (s_ff.trg_prev && !trg_s) : (!s_ff.trg_prev && trg_s);
    bus_trig = wr_en && (addr == OFS_TRIG) && wr_data[TRIG_BUS_BIT];
    per_clk = PER_CLK_W'(s_ff.per_us) * PER_CLK_W'(US_CYC);
    // frequency cap follows the shape and the count setting
    if (s_ff.shape == SH_RAMP)
      inc_cap = INC_RAMP_MAX;
    else if (s_ff.shape == SH_ARB)
      inc_cap = INC_ARB_MAX;
    else if ((s_ff.shape == SH_SINE || s_ff.shape == SH_SQUARE) && !s_ff.cyc_inf)
      inc_cap = INC_ARB_MAX;
    else
      inc_cap = INC_MAX;
    if (s_ff.freq < INC_MIN)
      inc = INC_MIN;
    else if (s_ff.freq > inc_cap)
      inc = inc_cap;
    else
      inc = s_ff.freq;
    // phase in degrees folded into 0..359
    ph_deg = s_ff.phase[9] ? s_ff.phase + 10'(PHASE_MAX_DEG) : s_ff.phase;
    if (ph_deg == 10'(PHASE_MAX_DEG))
      ph_deg = '0;
    if (s_ff.shape == SH_PULSE || noise)
      ph_off = '0;
    else
      ph_off = ACC_W'(ph_deg * PH_PER_DEG);
    acc_sum = {1'b0, s_ff.rel} + {1'b0, inc};
    wrap = acc_sum[ACC_W];
    last_cycle = !s_ff.cyc_inf && ((s_ff.done_cnt + CYC_W'(1)) == s_ff.cyc_cnt);
    // internal triggering also waits out the minimum idle gap
    unique case (s_ff.src)
      SRC_INT: trig_req = per_zero && (s_ff.gap >= 8'(GAP_CYC));
      SRC_EXT: trig_req = ext_edge || bus_trig;
      SRC_BUS, SRC_BUS2: trig_req = bus_trig;
    endcase
  end

  // ==========================================================================
  // registers, burst sequencer and read port
  // ==========================================================================
  always_comb
  begin
    nxt_s = s_ff;
    per_load = 1'b0;
    dly_load = 1'b0;
    nxt_s.trg_prev = trg_s;
    nxt_s.rd_data = '0;
    if (wr_en)
    begin
      case (addr)
        OFS_CTRL:
        begin
          nxt_s.en = wr_data[CTRL_EN_BIT];
          nxt_s.gated = wr_data[CTRL_GATED_BIT];
          nxt_s.src = wbc_src_e'(wr_data[CTRL_SRC_LSB +: 2]);
          nxt_s.pol = wr_data[CTRL_POL_BIT];
          nxt_s.slope = wr_data[CTRL_SLOPE_BIT];
          nxt_s.shape = wbc_shape_e'(wr_data[CTRL_SHAPE_LSB +: 3]);
          nxt_s.sweep = wr_data[CTRL_SWEEP_BIT] && !wr_data[CTRL_EN_BIT];
          nxt_s.modu = wr_data[CTRL_MOD_BIT] && !wr_data[CTRL_EN_BIT];
        end
        OFS_CYCLES:
        begin
          // stored in any mode; only the triggered path reads the count, the infinite bit also sets the frequency cap
          nxt_s.cyc_inf = wr_data[CYC_INF_BIT];
          if (wr_data[30:0] == '0)
            nxt_s.cyc_cnt = CYC_MIN;
          else if (wr_data[30:0] > 31'(CYC_MAX))
            nxt_s.cyc_cnt = CYC_MAX;
          else
            nxt_s.cyc_cnt = wr_data[CYC_W-1:0];
        end
        OFS_PERIOD:
        begin
          if (wr_data < PER_MIN_US)
            nxt_s.per_us = PER_MIN_US;
          else if (wr_data > PER_MAX_US)
            nxt_s.per_us = PER_MAX_US;
          else
            nxt_s.per_us = wr_data;
        end
        OFS_PHASE:
        begin
          if ($signed(wr_data) > PHASE_MAX_DEG)
            nxt_s.phase = 10'(PHASE_MAX_DEG);
          else if ($signed(wr_data) < -PHASE_MAX_DEG)
            nxt_s.phase = 10'(-PHASE_MAX_DEG);
          else
            nxt_s.phase = wr_data[9:0];
        end
        OFS_FREQ_LO: nxt_s.freq[31:0] = wr_data;
        OFS_FREQ_HI: nxt_s.freq[ACC_W-1:32] = wr_data[ACC_W-33:0];
        OFS_DELAY: nxt_s.delay = wr_data;
        default: ;
      endcase
    end
    if (rd_en)
    begin
      case (addr)
        OFS_CTRL: nxt_s.rd_data = DATA_W'({s_ff.shape, s_ff.modu, s_ff.sweep, s_ff.slope, s_ff.pol, s_ff.src,
          s_ff.gated, s_ff.en});
        OFS_CYCLES: nxt_s.rd_data = {s_ff.cyc_inf, 11'h000, s_ff.cyc_cnt};
        OFS_PERIOD: nxt_s.rd_data = s_ff.per_us;
        OFS_PHASE: nxt_s.rd_data = DATA_W'($signed(s_ff.phase));
        OFS_FREQ_LO: nxt_s.rd_data = s_ff.freq[31:0];
        OFS_FREQ_HI: nxt_s.rd_data = DATA_W'(s_ff.freq[ACC_W-1:32]);
        OFS_DELAY: nxt_s.rd_data = s_ff.delay;
        OFS_STATUS: nxt_s.rd_data = DATA_W'({gate_on, per_zero && s_ff.st != ST_IDLE, s_ff.en && !cfg_ok,
          s_ff.st == ST_RUN, s_ff.st == ST_DELAY, s_ff.st == ST_IDLE});
        default: nxt_s.rd_data = '0;
      endcase
    end
    // idle gap since the last burst ended, saturating
    if (s_ff.st == ST_IDLE && s_ff.gap < 8'(GAP_CYC))
      nxt_s.gap = s_ff.gap + 8'h01;
    unique case (s_ff.st)
      ST_IDLE:
      begin
        nxt_s.rel = '0;
        nxt_s.done_cnt = '0;
        if (active && s_ff.gated)
        begin
          if (gate_on)
            nxt_s.st = ST_RUN;
        end
        else if (active && trig_req)
        begin
          if (s_ff.delay == '0)
          begin
            nxt_s.st = ST_RUN;
            // only the internal source paces bursts; a stale long count would block it later
            per_load = (s_ff.src == SRC_INT);
          end
          else
          begin
            nxt_s.st = ST_DELAY;
            dly_load = 1'b1;
          end
        end
      end
      ST_DELAY:
      begin
        // triggers arriving here are dropped
        if (!active || s_ff.gated)
          nxt_s.st = ST_IDLE;
        else if (dly_zero)
        begin
          nxt_s.st = ST_RUN;
          per_load = (s_ff.src == SRC_INT);
        end
      end
      ST_RUN:
      begin
        nxt_s.gap = '0;
        nxt_s.rel = acc_sum[ACC_W-1:0];
        if (wrap)
          nxt_s.done_cnt = s_ff.done_cnt + CYC_W'(1);
        if (!active)
          nxt_s.st = ST_IDLE;
        else if (s_ff.gated && noise && !gate_on)
          nxt_s.st = ST_IDLE;
        else if (s_ff.gated && wrap && !gate_on)
          nxt_s.st = ST_IDLE;
        else if (!s_ff.gated && wrap && last_cycle)
          nxt_s.st = ST_IDLE;
        if (nxt_s.st == ST_IDLE)
          nxt_s.rel = '0;
      end
      default: nxt_s.st = ST_IDLE;
    endcase
    nxt_s.phase_word = nxt_s.rel + ph_off;
    nxt_s.wave_run = (nxt_s.st == ST_RUN);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      s_ff <= '0;
      s_ff.src <= SRC_INT;
      s_ff.gated <= 1'b0;
      s_ff.shape <= SH_SINE;
      s_ff.cyc_cnt <= CYC_DEF;
      s_ff.per_us <= PER_DEF_US;
      s_ff.freq <= INC_DEF;
      s_ff.delay <= DELAY_DEF;
      s_ff.st <= ST_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  assign rd_data = s_ff.rd_data;
  assign phase_word = s_ff.phase_word;
  assign wave_run = s_ff.wave_run;
  assign burst_hold = s_ff.en && !s_ff.wave_run;
  assign sweep_enable = s_ff.sweep;
  assign mod_enable = s_ff.modu;

  // ==========================================================================
  // checks
  // ==========================================================================
  logic [7:0] low_cnt_ff;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      low_cnt_ff <= '0;
    else if (s_ff.wave_run)
      low_cnt_ff <= '0;
    else if (low_cnt_ff != 8'hff)
      low_cnt_ff <= low_cnt_ff + 8'h01;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_gate_drop;
    s_ff.st == ST_RUN && s_ff.gated && !noise && !gate_on && active;
  endsequence

  sequence s_halt_start;
    !wave_run && phase_word == ph_off;
  endsequence

  AST_EXCLUSIVE: assert property (s_ff.en |-> !sweep_enable && !mod_enable)
    else $error("burst active together with sweep or modulation");
  AST_SHAPE_REFUSED: assert property (!cfg_ok |=> !wave_run)
    else $error("refused shape produced a burst");
  AST_COUNT_BOUND: assert property (s_ff.st == ST_RUN && !s_ff.cyc_inf && !s_ff.gated
    |-> s_ff.done_cnt < s_ff.cyc_cnt)
    else $error("burst ran past its cycle count");
  AST_COUNT_END: assert property (s_ff.st == ST_RUN && !s_ff.gated && active && wrap && last_cycle
    |=> s_halt_start)
    else $error("burst did not halt after last cycle");
  AST_GATE_FINISH: assert property (s_gate_drop and !wrap |=> wave_run)
    else $error("gated waveform cut before cycle end");
  AST_GATE_HOLD: assert property (s_gate_drop and wrap |=> s_halt_start)
    else $error("gated halt not at start phase");
  AST_NOISE_STOP: assert property (s_ff.st == ST_RUN && s_ff.gated && noise && !gate_on |=> !wave_run)
    else $error("noise kept running after gate drop");
  AST_GATED_MANUAL: assert property (s_ff.gated && s_ff.st == ST_IDLE && !gate_on && bus_trig
    |=> !wave_run && s_ff.st == ST_IDLE)
    else $error("manual trigger acted in gated mode");
  AST_GAP: assert property ($rose(wave_run) && !s_ff.gated && s_ff.src == SRC_INT
    |-> $past(low_cnt_ff) >= 8'(GAP_CYC))
    else $error("internal burst restarted inside the minimum gap");
  AST_BUSY_IGNORE: assert property (s_ff.st == ST_RUN && !s_ff.gated && ext_edge && !wrap && active
    |=> s_ff.done_cnt == $past(s_ff.done_cnt))
    else $error("trigger during burst disturbed the count");
  AST_DELAY: assert property (s_ff.st == ST_IDLE && dly_load |=> s_ff.st == ST_DELAY ##1 !wave_run)
    else $error("delayed trigger started the waveform at once");

endmodule

/* File: verif/wbc_trig_src.sv */
// rear trigger/gate source model: drives the asynchronous pin level
// assumes one bench process calls drive at a time
`timescale 1ns/10ps
module wbc_trig_src (
  output logic trig_gate_in
);
  initial trig_gate_in = 1'b0;

  // each edge lands 3 ns after the call, since the pin has no phase relation to the clock
  task automatic drive(input logic lvl, input int hold_ns);
    #3 trig_gate_in = lvl;
    #(hold_ns);
  endtask
endmodule

/* File: verif/wbc_burst_ctrl_tb.sv */
// self-checking bench of the burst controller: registers, bus, external, gated and internal bursts
// assumes the design files and the rear-pin source model are compiled before it
`timescale 1ns/10ps
module wbc_burst_ctrl_tb
  import wbc_pkg::*;
;
  logic ref_clk;
  logic rst_b;
  logic wr_en;
  logic rd_en;
  logic rd_pend = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic trig_gate_in, wave_run, burst_hold, sweep_enable, mod_enable;
  logic [ACC_W-1:0] phase_word;
  logic [DATA_W-1:0] rd_q[$];
  int len_q[$];
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int run_len = 0;
  int t0 = 0;
  int t1 = 0;
  int n, n0, cnt;
  integer seed = 32'hcf7c;
  logic [ADDR_W-1:0] ta[6] = '{OFS_CYCLES, OFS_CYCLES, OFS_PERIOD, OFS_PERIOD, OFS_PHASE, OFS_PHASE};
  logic [DATA_W-1:0] tw[6] = '{32'h0, 32'h001e8480, 32'h0, 32'hffffffff, 32'h190, 32'hfffffe70};
  logic [DATA_W-1:0] te[6] = '{32'h1, 32'h000f4240, 32'h1, PER_MAX_US, 32'h168, 32'hfffffe98};

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // one clock per microsecond unit keeps burst periods short
  wbc_burst_ctrl #(.US_CYC(1)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .trig_gate_in(trig_gate_in), .phase_word(phase_word),
    .wave_run(wave_run), .burst_hold(burst_hold), .sweep_enable(sweep_enable), .mod_enable(mod_enable));
  wbc_trig_src u_src (.trig_gate_in(trig_gate_in));

  // ====
  // helpers
  function automatic logic [31:0] cw(input int en, input int gated, input int src, input int pol, input int sh);
    cw = 32'(en) | 32'(gated) << CTRL_GATED_BIT | 32'(src) << CTRL_SRC_LSB | 32'(pol) << CTRL_POL_BIT
      | 32'(sh) << CTRL_SHAPE_LSB;
  endfunction

  task automatic chk(input string what, input logic [ACC_W-1:0] exp, input logic [ACC_W-1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_len(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // a gap cycle after each strobe keeps one assignment per signal per time step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd_q.push_back(e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_run(input logic lvl, input int lim, output int k);
    k = 0;
    while (wave_run !== lvl && k < lim)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k == lim)
      chk("wave_run level", lvl, wave_run);
  endtask

  task automatic give_verdict();
    chk_len("bursts never seen", 0, len_q.size());
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ====
  // monitor: read data and burst lengths against the oldest note
  always @(posedge ref_clk)
  begin
    cyc++;
    if (rd_pend)
      chk("rd_data", rd_q.pop_front(), rd_data);
    rd_pend <= rd_en;
    if (wave_run === 1'b1)
    begin
      if (run_len == 0)
      begin
        t0 = t1;
        t1 = cyc;
      end
      run_len++;
    end
    else if (run_len > 0)
    begin
      if (len_q.size() == 0)
        chk_len("unexpected burst", 0, run_len);
      else if (len_q[0] == 0)
        chk_len("gated length mod 8", 0, run_len % 8);
      else if (len_q[0] > 0)
        chk_len("burst length", len_q[0], run_len);
      if (len_q.size() > 0)
        void'(len_q.pop_front());
      run_len = 0;
    end
    if (cyc == 20000)
    begin
      errors++;
      give_verdict();
    end
  end

  // ====
  // main sequence
  initial
  begin
    rst_b <= 1'b0;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    addr <= 8'h00;
    wr_data <= 32'h0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_CYCLES, 32'h1);
    rdc(OFS_PERIOD, PER_DEF_US);
    rdc(OFS_PHASE, 32'h0);
    rdc(OFS_FREQ_LO, INC_DEF[31:0]);
    rdc(8'h24, 32'h0);
    rdc(OFS_STATUS, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      wr(ta[i], tw[i]);
      rdc(ta[i], te[i]);
    end
    $display("test defaults and limits done");
    wr(OFS_CTRL, 32'hc0);
    chk("sweep_enable", 1'b1, sweep_enable);
    chk("mod_enable", 1'b1, mod_enable);
    wr(OFS_FREQ_HI, 32'h2000);
    for (int s = 5; s < 7; s++)
    begin
      wr(OFS_CTRL, cw(1, 0, 2, 0, s) | 32'hc0);
      chk("sweep_enable", 1'b0, sweep_enable);
      chk("mod_enable", 1'b0, mod_enable);
      wr(OFS_TRIG, 32'h1);
      repeat (20) @(posedge ref_clk);
      chk("wave_run refused shape", 1'b0, wave_run);
    end
    $display("test exclusion and shapes done");
    for (int s = 0; s < 5; s++)
    begin
      cnt = 1 + ($random(seed) & 3);
      wr(OFS_CYCLES, cnt);
      wr(OFS_CTRL, cw(1, 0, 2, 0, s));
      // the capped ramp increment is rounded down, so its first cycle takes one clock more
      len_q.push_back((s == 2) ? 100 * cnt + 1 : 8 * cnt);
      wr(OFS_TRIG, 32'h1);
      wr(OFS_TRIG, 32'h1); // lands mid-burst, so it must be dropped
      wait_run(1'b0, 500, n);
    end
    wr(OFS_CTRL, cw(1, 0, 2, 0, 0));
    len_q.push_back(8 * cnt);
    wr(OFS_TRIG, 32'h1);
    wait_run(1'b1, 20, n0);
    wait_run(1'b0, 100, n);
    @(posedge ref_clk);
    chk("phase_word parked", 0, phase_word);
    chk("burst_hold", 1'b1, burst_hold);
    wr(OFS_DELAY, 32'h5);
    len_q.push_back(8 * cnt);
    wr(OFS_TRIG, 32'h1);
    wait_run(1'b1, 20, n);
    // one more clock passes while the expired delay counter is seen
    chk_len("trigger delay", n0 + 5 + 1, n);
    wait_run(1'b0, 100, n);
    wr(OFS_DELAY, 32'h0);
    $display("test bus bursts done");
    wr(OFS_CYCLES, 32'h2);
    wr(OFS_CTRL, cw(1, 0, 1, 0, 0));
    len_q.push_back(16);
    u_src.drive(1'b1, 40);
    u_src.drive(1'b0, 30);
    u_src.drive(1'b1, 40); // edge inside the burst
    u_src.drive(1'b0, 30);
    @(posedge ref_clk);
    wait_run(1'b0, 100, n);
    wr(OFS_CTRL, cw(1, 0, 1, 0, 0) | 32'h20);
    len_q.push_back(16);
    u_src.drive(1'b1, 40);
    chk("wave_run rising edge on falling slope", 1'b0, wave_run);
    u_src.drive(1'b0, 30);
    wait_run(1'b1, 20, n);
    wait_run(1'b0, 100, n);
    $display("test external trigger done");
    wr(OFS_PHASE, 32'h5a);
    wr(OFS_CTRL, cw(1, 1, 2, 0, 0));
    wr(OFS_CYCLES, 32'h3);
    rdc(OFS_CYCLES, 32'h3);
    wr(OFS_TRIG, 32'h1);
    repeat (10) @(posedge ref_clk);
    chk("wave_run manual in gated", 1'b0, wave_run);
    len_q.push_back(0);
    u_src.drive(1'b1, 300);
    chk("wave_run gate on", 1'b1, wave_run);
    u_src.drive(1'b0, 0);
    @(posedge ref_clk);
    wait_run(1'b0, 50, n);
    @(posedge ref_clk);
    chk("phase_word held", ACC_W'(90) * PH_PER_DEG, phase_word);
    chk("burst_hold", 1'b1, burst_hold);
    len_q.push_back(0);
    wr(OFS_CTRL, cw(1, 1, 2, 1, 0)); // pin low now reads as gate asserted
    repeat (20) @(posedge ref_clk);
    chk("wave_run gate_active_low gate", 1'b1, wave_run);
    u_src.drive(1'b1, 0);
    @(posedge ref_clk);
    wait_run(1'b0, 50, n);
    len_q.push_back(-1);
    wr(OFS_CTRL, cw(1, 1, 2, 0, 5));
    repeat (10) @(posedge ref_clk);
    u_src.drive(1'b0, 0);
    @(posedge ref_clk);
    wait_run(1'b0, 5, n);
    len_q.push_back(24);
    wr(OFS_CTRL, cw(1, 0, 2, 0, 0));
    wr(OFS_TRIG, 32'h1);
    wait_run(1'b0, 100, n);
    @(posedge ref_clk);
    chk("phase_word after burst", ACC_W'(90) * PH_PER_DEG, phase_word);
    $display("test gated mode done");
    wr(OFS_PERIOD, 32'h1);
    for (int i = 0; i < 4; i++)
      len_q.push_back(24);
    wr(OFS_CTRL, cw(1, 0, 0, 0, 0));
    wait_run(1'b1, 200, n);
    wait_run(1'b0, 200, n);
    wait_run(1'b1, 200, n);
    @(posedge ref_clk);
    chk_len("stretched period in range", 1, int'(t1 - t0 >= 45 && t1 - t0 <= 48));
    wait_run(1'b0, 200, n);
    wr(OFS_PERIOD, 32'h64);
    wait_run(1'b1, 200, n);
    wait_run(1'b0, 200, n);
    wait_run(1'b1, 200, n);
    @(posedge ref_clk);
    chk_len("start to start", 100, t1 - t0);
    wait_run(1'b0, 200, n);
    wr(OFS_CTRL, 32'h0);
    $display("test internal trigger done");
    give_verdict();
  end
endmodule
